// ===== core/sense_pkg.sv
package sense_pkg;

  // ==========================================================================
  // Register map, byte addresses on the AXI4-Lite bus
  // ==========================================================================
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] FAULT_OFS    = 8'h08;
  localparam logic [7:0] SENSE_OFS    = 8'h0c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int POL_LSB     = 0;  // Control: offset_polarity_bit per channel, bits 1:0.
  localparam int SAMPLED_BIT = 2;  // Control: sampled (track and hold) sensing mode.
  localparam int SEL_BIT     = 3;  // Control: channel routed to the sense output.
  localparam int CH_ON_LSB   = 0;  // Status: channel state bits OD0 and OD1.
  localparam int PREWARN_BIT = 8;  // Fault: temp_prewarn_flag at OD8.
  localparam int IRQ_PREWARN = 0;  // Interrupt: prewarning flag was set.
  localparam int IRQ_CH_LSB  = 1;  // Interrupt: channel 0 or 1 changed state.
  localparam int NUM_CH      = 2;
  localparam int NUM_IRQ     = 3;

  // ==========================================================================
  // Values after reset and bus answers
  // ==========================================================================
  localparam logic [1:0] POL_RST      = 2'h0;
  localparam logic [2:0] MASK_RST     = 3'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage : sense_pkg

// ===== core/sense_if.sv
`timescale 1ns/100ps

// Carries the sense controls to the datapath and the sensed value back.
interface sense_if #(
  parameter int W = 12
);
  logic [1:0]          polarity;
  logic                sampled;
  logic                sel;
  logic [1:0]          chOn;
  logic [W-1:0]        loadVal;
  logic [W-1:0]        offsetVal;
  logic signed [W+1:0] senseVal;

  modport ctrl (output polarity, sampled, sel, chOn, loadVal, offsetVal, input senseVal);
  modport dp   (input polarity, sampled, sel, chOn, loadVal, offsetVal, output senseVal);
endinterface : sense_if

// ===== core/sense_track_hold.sv
`timescale 1ns/100ps

module sense_track_hold
  import sense_pkg::*;
#(
  parameter int W = 12
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Sense controls and result.
  sense_if.dp      sio
);

  typedef struct packed {
    logic signed [W+1:0] senseVal;
    logic                selPrev;
  } dp_state_t;

  dp_state_t s, n;

  logic                on;
  logic                pol;
  logic signed [W+1:0] loadExt;
  logic signed [W+1:0] offExt;
  logic signed [W+1:0] trackVal;

  // ==========================================================================
  // Offset sign and tracked value
  // ==========================================================================
  // The random offset term is added or subtracted by the polarity bit.
  assign on       = sio.chOn[sio.sel];
  assign pol      = sio.polarity[sio.sel];
  assign loadExt  = signed'({2'h0, sio.loadVal});
  assign offExt   = signed'({2'h0, sio.offsetVal});
  assign trackVal = pol ? (loadExt + offExt) : (loadExt - offExt);  // R1

  // Track while on; when off, hold in sampled mode, else nothing flows.
  always_comb begin
    n = s;
    n.selPrev = sio.sel;
    if (on) begin
      n.senseVal = trackVal;  // R1
    end else if (!sio.sampled || (s.selPrev != sio.sel)) begin
      // A new channel empties the hold store; its old value is lost.
      n.senseVal = '0;
    end else begin
      n.senseVal = s.senseVal;  // R2 R3
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sio.senseVal = s.senseVal;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pos_offset_a: assert property (on && pol |=> s.senseVal == $past(loadExt + offExt)) // R1
    else $error("positive offset not applied");
  neg_offset_a: assert property (on && !pol |=> s.senseVal == $past(loadExt - offExt)) // R1
    else $error("negative offset not applied");
  off_capture_a: assert property (
    on ##1 (!on && sio.sampled && $stable(sio.sel)) |=> s.senseVal == $past(trackVal, 2)) // R2
    else $error("sample at switch-off lost");
  hold_stable_a: assert property (
    (!on && sio.sampled && $stable(sio.sel)) [*2] |-> $stable(s.senseVal)) // R3
    else $error("held sense value moved while off");

  hold_cov_c: cover property (on ##1 (!on && sio.sampled) [*3]);
  pol_flip_c: cover property (!on && sio.sampled && $changed(pol));

endmodule : sense_track_hold

// ===== core/sense_status_flags.sv
`timescale 1ns/100ps

// Operation
// R1 - The sensed value carries the random offset with plus sign when the channel's polarity bit is 1 and minus sign when 0.
// R2 - In sampled mode the value at the switch-off instant is held, taken with the polarity that was active then.
// R3 - While the channel is off in sampled mode a polarity change leaves the held value untouched.
// R4 - The controller turns the channel on at least once after a polarity change before its second reading.
// R5 - In normal mode the prewarning flag sets when the ground temperature passes the threshold, and the channels stay on.
// R6 - The prewarning flag clears only on a fault register read made after the temperature fell below the threshold.
// R7 - Each channel's on/off state is reported live in status bits 0 and 1, one per channel.
// R8 - A state bit reads high when the output is above half supply and low otherwise.
module sense_status_flags
  import sense_pkg::*;
#(
  parameter int W      = 12,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // AXI4-Lite write address and data.
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              wvalid,
  output wire logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // AXI4-Lite write response.
  output wire logic              bvalid,
  input  wire logic              bready,
  output wire logic [1:0]        bresp,
  // AXI4-Lite read.
  input  wire logic              arvalid,
  output wire logic              arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  output wire logic              rvalid,
  input  wire logic              rready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  // Channel control and state.
  input  wire logic [1:0]        chCmd,
  input  wire logic [1:0]        chOutHigh,
  output wire logic [1:0]        chDrive,
  // Temperature comparator and operating mode.
  input  wire logic              normalMode,
  input  wire logic              tempOver,
  // Sense inputs and result.
  input  wire logic [W-1:0]      loadVal,
  input  wire logic [W-1:0]      offsetVal,
  output wire logic [W+1:0]      senseOut,
  // Interrupt.
  output wire logic              irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic              awReady;
    logic              awHave;
    logic [ADDR_W-1:0] awAddr;
    logic              wReady;
    logic              wHave;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic [1:0]        polarity;
    logic              sampled;
    logic              sel;
    logic              prewarn;
    logic [1:0]        chOn;
    logic [1:0]        chDrive;
    logic [2:0]        irqStat;
    logic [2:0]        irqMask;
    logic              irq;
  } state_t;

  state_t s, n;

  logic awFire;
  logic wFire;
  logic arFire;
  logic doWrite;
  logic faultRead;
  logic prewarnClr;
  logic [NUM_IRQ-1:0] evt;

  sense_if #(.W(W)) sio ();

  // ==========================================================================
  // Handshake decode
  // ==========================================================================
  // A channel moves one item when its valid meets our registered ready.
  assign awFire     = awvalid && s.awReady;
  assign wFire      = wvalid && s.wReady;
  assign arFire     = arvalid && s.arReady;
  assign doWrite    = s.awHave && s.wHave && !s.bValid;
  assign faultRead  = arFire && (araddr == FAULT_OFS);
  // A read while still hot leaves the flag standing.
  assign prewarnClr = faultRead && !tempOver;  // R6

  // Register read multiplexer; reserved bits read as zero.
  function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a, input state_t st,
                                          input logic signed [W+1:0] sv);
    logic [31:0] d;
    d = '0;
    case (a)
      CTRL_OFS: begin
        d[POL_LSB +: NUM_CH] = st.polarity;
        d[SAMPLED_BIT]       = st.sampled;
        d[SEL_BIT]           = st.sel;
      end
      STAT_OFS: begin
        d[CH_ON_LSB +: NUM_CH] = st.chOn;  // R7
      end
      FAULT_OFS: begin
        d[PREWARN_BIT] = st.prewarn;
      end
      SENSE_OFS: begin
        d = 32'(sv);
      end
      IRQ_STAT_OFS: begin
        d[NUM_IRQ-1:0] = st.irqStat;
      end
      IRQ_MASK_OFS: begin
        d[NUM_IRQ-1:0] = st.irqMask;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : readMux

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFS) || (a == STAT_OFS) || (a == FAULT_OFS) ||
           (a == SENSE_OFS) || (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
  endfunction : mapped

  // ==========================================================================
  // Next state
  // ==========================================================================
  // All register, flag and bus behaviour in one pass; event sets are
  // applied last so that they win over any clear in the same cycle.
  always_comb begin
    n = s;

    // Channel state is sampled every cycle, so it reads in real time.
    n.chOn = chOutHigh;  // R7 R8
    // The prewarning flag never gates the channel drive.
    n.chDrive = chCmd;  // R5

    // Write path: address and data are taken in either order.
    if (doWrite) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = mapped(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (s.wStrb[0]) begin
        case (s.awAddr)
          CTRL_OFS: begin
            n.polarity = s.wData[POL_LSB +: NUM_CH];
            n.sampled  = s.wData[SAMPLED_BIT];
            n.sel      = s.wData[SEL_BIT];
          end
          IRQ_STAT_OFS: begin
            n.irqStat = s.irqStat & ~s.wData[NUM_IRQ-1:0];
          end
          IRQ_MASK_OFS: begin
            n.irqMask = s.wData[NUM_IRQ-1:0];
          end
          default: begin
            n.irqMask = s.irqMask;
          end
        endcase
      end
    end
    if (s.bValid && bready) begin
      n.bValid = 1'b0;
    end
    if (awFire) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wFire) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    // Only one write may be in flight; ready drops until its response leaves.
    n.awReady = !n.awHave && !n.bValid;
    n.wReady  = !n.wHave && !n.bValid;

    // Read path: one read in flight, data registered one cycle after arFire.
    if (s.rValid && rready) begin
      n.rValid = 1'b0;
    end
    if (arFire) begin
      n.rValid = 1'b1;
      n.rData  = readMux(araddr, s, sio.senseVal);
      n.rResp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    n.arReady = !n.rValid;

    // Prewarning flag: clear on a qualified read, then set while hot in normal mode.
    if (prewarnClr) begin
      n.prewarn = 1'b0;  // R6
    end
    if (normalMode && tempOver) begin
      n.prewarn = 1'b1;  // R5
    end

    // Sticky interrupt bits; a new event beats a write-one clear.
    evt[IRQ_PREWARN]              = n.prewarn && !s.prewarn;
    evt[IRQ_CH_LSB +: NUM_CH]     = n.chOn ^ s.chOn;
    n.irqStat = n.irqStat | evt;
    n.irq     = |(n.irqStat & n.irqMask);
  end

  // Synchronous reset puts the whole state to zero, masks included.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // Sense datapath
  // ==========================================================================
  assign sio.polarity  = s.polarity;
  assign sio.sampled   = s.sampled;
  assign sio.sel       = s.sel;
  assign sio.chOn      = s.chOn;
  assign sio.loadVal   = loadVal;
  assign sio.offsetVal = offsetVal;

  sense_track_hold #(.W(W)) u_sense (
    .clk   (clk),
    .rst_n (rst_n),
    .sio   (sio.dp)
  );

  // ==========================================================================
  // Outputs, each straight from a flip-flop
  // ==========================================================================
  assign awready  = s.awReady;
  assign wready   = s.wReady;
  assign bvalid   = s.bValid;
  assign bresp    = s.bResp;
  assign arready  = s.arReady;
  assign rvalid   = s.rValid;
  assign rdata    = s.rData;
  assign rresp    = s.rResp;
  assign chDrive  = s.chDrive;
  assign senseOut = sio.senseVal;
  assign irq      = s.irq;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  prewarn_set_a: assert property (normalMode && tempOver |=> s.prewarn) // R5
    else $error("prewarning flag not set when hot");
  drive_kept_a: assert property (s.prewarn ##1 1'b1 |-> chDrive == $past(chCmd)) // R5
    else $error("channel drive altered by prewarning");
  prewarn_hold_a: assert property (s.prewarn && !prewarnClr |=> s.prewarn) // R6
    else $error("prewarning flag cleared without qualified read");
  prewarn_clr_a: assert property (
    s.prewarn && prewarnClr && !(normalMode && tempOver) |=> !s.prewarn) // R6
    else $error("qualified fault read did not clear flag");
  state_live_a: assert property (1'b1 |=> s.chOn == $past(chOutHigh)) // R7 R8
    else $error("channel state bits not live");
  state_read_a: assert property (
    arFire && araddr == STAT_OFS |=> rvalid && rdata[CH_ON_LSB +: NUM_CH] == $past(s.chOn)) // R7
    else $error("status read lost channel state");
  irq_level_a: assert property (1'b1 |=> irq == |(s.irqStat & s.irqMask))
    else $error("interrupt output disagrees with status and mask");
  // Outside normal mode nothing may raise the flag, whatever the temperature.
  prewarn_mode_a: assert property (!s.prewarn && !(normalMode && tempOver) |=> !s.prewarn) // R5
    else $error("prewarning flag set outside normal mode");
  // An event latches its status bit even when a write of one lands in that cycle.
  prewarn_evt_a: assert property ( // R5
    normalMode && tempOver && !s.prewarn |=> s.irqStat[IRQ_PREWARN])
    else $error("prewarning event not latched");
  // A write of one clears the bit when no new event meets it.
  irq_clear_a: assert property (
    doWrite && s.wStrb[0] && s.awAddr == IRQ_STAT_OFS && s.wData[IRQ_PREWARN] &&
    !(normalMode && tempOver && !s.prewarn) |=> !s.irqStat[IRQ_PREWARN])
    else $error("prewarning status bit not cleared by a write of one");
  // Every change of a channel's state latches that channel's status bit.
  // The reset term keeps the release edge, where the state was forced, out.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch_evt
    ch_evt_a: assert property (rst_n && chOutHigh[c] != s.chOn[c] |=> s.irqStat[IRQ_CH_LSB + c])
      else $error("channel change not latched");
  end

  // ==========================================================================
  // Bus checks
  // ==========================================================================
  // Each answer leaves on the edge that hands it over, so the master never
  // takes the same word twice.
  resp_taken_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated after it was taken");
  data_taken_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated after it was taken");

  // Each direction has a single slot, so readiness stays down while an
  // answer is pending; an early ready would overwrite the held request.
  aw_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write channels open while a response is pending");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read address open while read data is pending");

  // The answer comes on the edge after the request is complete.
  write_answer_a: assert property (doWrite |=> bvalid)
    else $error("write response missing");
  read_answer_a: assert property (arFire |=> rvalid)
    else $error("read data missing");

  // Unmapped offsets answer with an error and read as zero.
  unmapped_rd_a: assert property (
    arFire && !mapped(araddr) |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  unmapped_wr_a: assert property (doWrite && !mapped(s.awAddr) |=> bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  early_read_c: cover property (s.prewarn && faultRead && tempOver ##1 s.prewarn);
  late_clear_c: cover property (s.prewarn && prewarnClr ##1 !s.prewarn);
  both_on_c:    cover property (s.chOn == 2'h3);

endmodule : sense_status_flags

// ===== test/host_model.sv
`timescale 1ns/100ps

// ====================================================
// Bus master standing in for the external controller.
// ====================================================
module host_model (
  // Clock.
  input  wire logic        clk,
  // Write channels.
  output logic             awvalid,
  input  wire logic        awready,
  output logic [7:0]       awaddr,
  output logic [2:0]       awprot,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels.
  output logic             arvalid,
  input  wire logic        arready,
  output logic [7:0]       araddr,
  output logic [2:0]       arprot,
  input  wire logic        rvalid,
  output logic             rready,
  // Raised when an answer never came.
  output logic             hang
);
  // Idle bus from time zero; protection bits stay unused.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hang} = '0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hf;
  end

  // Released payloads are inverted so a stale value is never trusted.
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end while (!done && n < 200);
    if (!done) hang <= 1'b1;
  endtask : busWrite

  // A register read; a read of the fault register may clear the prewarning flag.
  task automatic busRead(input logic [7:0] a);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end while (!done && n < 200);
    if (!done) hang <= 1'b1;
  endtask : busRead
endmodule : host_model

// ===== test/sense_status_flags_tb.sv
`timescale 1ns/100ps

module sense_status_flags_tb;
  import sense_pkg::*;
  localparam int W = 12;
  // ====================================================
  // Signals
  // ====================================================
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, normalMode, tempOver, irq, hang;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, chCmd, chOutHigh, chDrive, prevCmd;
  logic [W-1:0] loadVal, offsetVal, ld, of;
  logic [W+1:0] senseOut;
  logic [33:0] notes[$];
  int fails, comparisons, liveCnt;
  int seed = 32'h511446f9;

  sense_status_flags #(.W(W)) DUT (.clk, .rst_n, .awvalid, .awready, .awaddr,
    .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .chCmd,
    .chOutHigh, .chDrive, .normalMode, .tempOver, .loadVal, .offsetVal, .senseOut, .irq);

  host_model host (.clk, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .hang);

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Unanswered notes count as mismatches too.
  task automatic report_and_stop();
    fails += notes.size();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs = RESP_OKAY);
    notes.push_back({rs, 32'h0});
    host.busWrite(a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs = RESP_OKAY);
    notes.push_back({rs, d});
    host.busRead(a);
  endtask : rd

  // Expected sense word, sign-extended like the register.
  function automatic logic [31:0] sx(input logic p, input logic [W-1:0] l, o);
    logic signed [W+1:0] v;
    v = p ? $signed({2'b0, l}) + $signed({2'b0, o}) : $signed({2'b0, l}) - $signed({2'b0, o});
    return 32'(v);
  endfunction : sx

  // Random channel commands; the drive must follow them whatever the flags say.
  always @(posedge clk) chCmd <= 2'($random(seed));

  // Watcher: bus answers are matched to the oldest note when accepted.
  always @(posedge clk) begin : watch
    logic [33:0] nt;
    if (bvalid && bready && notes.size() > 0) begin
      nt = notes.pop_front();
      check("bresp", 32'(bresp), 32'(nt[33:32]));
    end
    if (rvalid && rready && notes.size() > 0) begin
      nt = notes.pop_front();
      check("rdata", rdata, nt[31:0]);
      check("rresp", 32'(rresp), 32'(nt[33:32]));
    end
    if (rst_n && liveCnt > 0) check("chDrive", 32'(chDrive), 32'(prevCmd));
    prevCmd = chCmd;
    liveCnt = rst_n ? liveCnt + 1 : 0;
    if (hang) begin
      fails++;
      report_and_stop();
    end
  end

  // ====================================================
  // Main sequence
  // ====================================================
  initial begin
    rst_n = 1'b0;
    {chOutHigh, normalMode, tempOver} = '0;
    loadVal = '0;
    offsetVal = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTRL_OFS, 32'(POL_RST));
    rd(IRQ_MASK_OFS, 32'(MASK_RST));
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'hff, RESP_SLVERR);
    wr(STAT_OFS, 32'h3);
    // State bits follow the half-supply comparators; the write above is ignored.
    for (int i = 0; i < 4; i++) begin
      chOutHigh <= 2'(i);
      repeat (2) @(posedge clk);
      rd(STAT_OFS, 32'(i));
    end
    // Offset sign per channel, the other channel set the opposite way.
    for (int k = 0; k < 4; k++) begin
      ld = W'($random(seed));
      of = W'($random(seed));
      loadVal <= ld;
      offsetVal <= of;
      wr(CTRL_OFS, {28'h0, k[1], 1'b0, ~(k[0] ^ k[1]), k[0] ^ k[1]});
      repeat (2) @(posedge clk);
      check("senseOut", 32'($signed(senseOut)), sx(k[0], ld, of));
      rd(SENSE_OFS, sx(k[0], ld, of));
    end
    // Sampled mode keeps the switch-off value whatever the polarity does later.
    chOutHigh <= 2'b00;
    wr(CTRL_OFS, 32'h5);
    chOutHigh <= 2'b01;
    repeat (3) @(posedge clk);
    chOutHigh <= 2'b00;
    repeat (3) @(posedge clk);
    wr(CTRL_OFS, 32'h4);
    ld = ~ld;
    loadVal <= ld;
    check("senseOut", 32'($signed(senseOut)), sx(1'b1, ~ld, of));
    rd(SENSE_OFS, sx(1'b1, ~ld, of));
    chOutHigh <= 2'b01;
    repeat (3) @(posedge clk);
    chOutHigh <= 2'b00;
    repeat (3) @(posedge clk);
    check("senseOut", 32'($signed(senseOut)), sx(1'b0, ld, of));
    rd(SENSE_OFS, sx(1'b0, ld, of));
    wr(CTRL_OFS, 32'h0);
    rd(SENSE_OFS, 32'h0);
    // Prewarning flag, its interrupt, masking and clearing.
    chOutHigh <= 2'b11;
    repeat (3) @(posedge clk);
    // Both channels have toggled by now; the prewarning bit has not.
    rd(IRQ_STAT_OFS, 32'h6);
    wr(IRQ_MASK_OFS, 32'h1);
    wr(IRQ_STAT_OFS, 32'h7);
    repeat (2) @(posedge clk);
    check("irq", 32'(irq), 32'h0);
    normalMode <= 1'b1;
    tempOver <= 1'b1;
    repeat (3) @(posedge clk);
    check("irq", 32'(irq), 32'h1);
    rd(FAULT_OFS, 32'h100);
    rd(STAT_OFS, 32'h3);
    wr(IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge clk);
    check("irq", 32'(irq), 32'h0);
    tempOver <= 1'b0;
    rd(IRQ_STAT_OFS, 32'h1);
    rd(FAULT_OFS, 32'h100);
    rd(FAULT_OFS, 32'h0);
    wr(IRQ_STAT_OFS, 32'h1);
    rd(IRQ_STAT_OFS, 32'h0);
    normalMode <= 1'b0;
    tempOver <= 1'b1;
    repeat (3) @(posedge clk);
    rd(FAULT_OFS, 32'h0);
    // Let the watcher take the last answer before the notes are counted.
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule : sense_status_flags_tb
